// ### src/swdt_pkg.sv
// shared constants and types of the startup watchdog timer
package swdt_pkg;

  // ----------------------------------------------------------------------------
  // counter geometry
  // ----------------------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int REL_W = 8;
  localparam int PRE_W = 7;

  // ----------------------------------------------------------------------------
  // divider choices and the prescaler terminal values
  // ----------------------------------------------------------------------------
  localparam int DIV_LOW = 2;
  localparam int DIV_HIGH = 128;
  localparam logic [PRE_W-1:0] PRE_LAST_HIGH = 7'(DIV_HIGH - 1);
  localparam logic [PRE_W-1:0] PRE_LAST_LOW = 7'(DIV_LOW - 1);
  localparam logic [PRE_W-1:0] PRE_RST = 7'h00;

  // ----------------------------------------------------------------------------
  // reset values, terminal count and reload low byte
  // ----------------------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [REL_W-1:0] RELOAD_RST = 8'h00;
  localparam logic DIV128_RST = 1'b0;
  localparam logic [REL_W-1:0] RELOAD_LOW_BYTE = 8'h00;

  // ----------------------------------------------------------------------------
  // monitored intervals at the reference system clock
  // ----------------------------------------------------------------------------
  localparam int REF_CLK_MHZ = 25;
  localparam int MIN_INTERVAL_NS = 20000;
  localparam int MAX_INTERVAL_MS = 336;
  localparam int DEFAULT_INTERVAL_US = 5240;

  // ----------------------------------------------------------------------------
  // supervision state
  // ----------------------------------------------------------------------------
  typedef enum logic [3:0] {
    SWDT_INIT_RUN = 4'b0001,
    SWDT_INIT_OFF = 4'b0010,
    SWDT_DONE_RUN = 4'b0100,
    SWDT_DONE_OFF = 4'b1000
  } swdt_state_e;

endpackage

// ### src/swdt_ctl_if.sv
// control and status bundle between the supervisor and the counter
`timescale 1ns/10ps
interface swdt_ctl_if;
  logic run;
  logic div128;
  logic service;
  logic [swdt_pkg::REL_W-1:0] reload;
  logic tick;
  logic overflow;
  logic [swdt_pkg::CNT_W-1:0] count;

  modport supervisor (output run, output div128, output service, output reload,
                      input tick, input overflow, input count);
  modport counter (input run, input div128, input service, input reload,
                   output tick, output overflow, output count);
endinterface

// ### src/swdt_counter.sv
// prescaler and 16-bit watchdog counter
`timescale 1ns/10ps
module swdt_counter #(
  parameter int CNT_W = swdt_pkg::CNT_W
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  swdt_ctl_if.counter ctl
);

  generate
    if (CNT_W != swdt_pkg::CNT_W)
    begin : g_bad_width
      $error("counter width must match the shared counter width");
    end
  endgenerate

  logic [swdt_pkg::PRE_W-1:0] pre_reg;
  logic [swdt_pkg::CNT_W-1:0] count_reg;
  logic [swdt_pkg::PRE_W-1:0] gap_reg;
  logic gap_valid_reg;
  logic div_prev_reg;

  // ----------------------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------------------
  // tick on the last prescaler state of the selected divider
  assign ctl.tick = ctl.run && !ctl.service &&
                    (ctl.div128 ? (pre_reg == swdt_pkg::PRE_LAST_HIGH) : pre_reg[0]);
  assign ctl.overflow = ctl.tick && (count_reg == swdt_pkg::CNT_MAX);
  assign ctl.count = count_reg;

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      pre_reg <= swdt_pkg::PRE_RST;
    else if (ctl.service || ctl.overflow)
      pre_reg <= swdt_pkg::PRE_RST;
    else if (ctl.run)
      pre_reg <= 7'(pre_reg + 7'h01);
  end

  // ----------------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      count_reg <= swdt_pkg::CNT_RST;
    else if (ctl.service)
      count_reg <= {ctl.reload, swdt_pkg::RELOAD_LOW_BYTE};
    else if (ctl.tick)
      count_reg <= 16'(count_reg + 16'h0001);
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  // cycles since the last tick, for the divider check
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      gap_reg <= swdt_pkg::PRE_RST;
      gap_valid_reg <= 1'b0;
      div_prev_reg <= 1'b0;
    end
    else
    begin
      div_prev_reg <= ctl.div128;
      if (ctl.tick)
      begin
        gap_reg <= swdt_pkg::PRE_RST;
        gap_valid_reg <= 1'b1;
      end
      else if (ctl.service || !ctl.run || (ctl.div128 != div_prev_reg))
      begin
        gap_reg <= swdt_pkg::PRE_RST;
        gap_valid_reg <= 1'b0;
      end
      else
        gap_reg <= 7'(gap_reg + 7'h01);
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  property p_tick_spacing;
    ctl.tick && gap_valid_reg && (ctl.div128 == div_prev_reg) |->
      gap_reg == (ctl.div128 ? swdt_pkg::PRE_LAST_HIGH : swdt_pkg::PRE_LAST_LOW);
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("watchdog tick spacing differs from selected divider");

  property p_count_steps;
    ctl.tick && !ctl.overflow |=> count_reg == 16'($past(count_reg) + 16'h0001);
  endproperty
  a_count_steps: assert property (p_count_steps)
    else $error("watchdog count did not step by one on tick");

  property p_count_holds;
    !ctl.tick && !ctl.service |=> $stable(count_reg);
  endproperty
  a_count_holds: assert property (p_count_holds)
    else $error("watchdog count changed without tick");

  property p_service_load;
    ctl.service |=> count_reg == {$past(ctl.reload), swdt_pkg::RELOAD_LOW_BYTE};
  endproperty
  a_service_load: assert property (p_service_load)
    else $error("service did not load reload value into high byte");

  property p_overflow_wraps;
    ctl.overflow |=> count_reg == swdt_pkg::CNT_RST && pre_reg == swdt_pkg::PRE_RST;
  endproperty
  a_overflow_wraps: assert property (p_overflow_wraps)
    else $error("overflow did not restart the full count");

endmodule

// ### src/swdt_top.sv
// startup watchdog supervisor: command handling, reset generation, reset pin
`timescale 1ns/10ps
// Contract
// - watchdog runs after every reset; disable accepted only before end of init.
// - on overflow raise internal reset and drive reset output low.
// - 16-bit counter steps on system clock divided by 2 or 128.
// - service loads counter high byte from the reload value.
// - reload and divider span about 20 us to 336 ms at 25 MHz.
// - default interval after reset is 5.24 ms at 25 MHz.
// - end of init releases reset output and closes the disable window.
module swdt_top #(
  parameter int CNT_W = swdt_pkg::CNT_W
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic service_watchdog_cmd_in,
  input wire logic disable_watchdog_cmd_in,
  input wire logic end_of_init_cmd_in,
  input wire logic cfg_write_in,
  input wire logic cfg_div128_in,
  input wire logic [swdt_pkg::REL_W-1:0] cfg_reload_in,
  output logic hw_reset_out,
  output logic reset_out_n_out,
  output logic wdt_active_out,
  output logic init_done_out,
  output logic [swdt_pkg::CNT_W-1:0] wdt_count_out
);

  generate
    if (CNT_W != swdt_pkg::CNT_W)
    begin : g_bad_width
      $error("watchdog width must be 16");
    end
  endgenerate

  swdt_pkg::swdt_state_e state_reg;
  swdt_pkg::swdt_state_e state_next;
  logic div128_reg;
  logic [swdt_pkg::REL_W-1:0] wdt_reload_value_reg;
  logic ovf;

  swdt_ctl_if ctl ();

  swdt_counter #(
    .CNT_W(CNT_W)
  ) u_counter (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .ctl(ctl)
  );

  // ----------------------------------------------------------------------------
  // supervision state
  // ----------------------------------------------------------------------------
  function automatic logic is_pre_init(input swdt_pkg::swdt_state_e s);
    is_pre_init = (s == swdt_pkg::SWDT_INIT_RUN) || (s == swdt_pkg::SWDT_INIT_OFF);
  endfunction

  function automatic logic is_running(input swdt_pkg::swdt_state_e s);
    is_running = (s == swdt_pkg::SWDT_INIT_RUN) || (s == swdt_pkg::SWDT_DONE_RUN);
  endfunction

  assign ovf = ctl.overflow;

  always_comb
  begin
    state_next = state_reg;
    if (ovf)
      state_next = swdt_pkg::SWDT_INIT_RUN;
    else
    begin
      case (state_reg)
        swdt_pkg::SWDT_INIT_RUN:
        begin
          if (end_of_init_cmd_in)
            state_next = swdt_pkg::SWDT_DONE_RUN;
          else if (disable_watchdog_cmd_in)
            state_next = swdt_pkg::SWDT_INIT_OFF;
        end
        swdt_pkg::SWDT_INIT_OFF:
        begin
          if (end_of_init_cmd_in)
            state_next = swdt_pkg::SWDT_DONE_OFF;
        end
        swdt_pkg::SWDT_DONE_RUN:
          state_next = swdt_pkg::SWDT_DONE_RUN;
        swdt_pkg::SWDT_DONE_OFF:
          state_next = swdt_pkg::SWDT_DONE_OFF;
        default:
          state_next = swdt_pkg::SWDT_INIT_RUN;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      state_reg <= swdt_pkg::SWDT_INIT_RUN;
    else
      state_reg <= state_next;
  end

  // ----------------------------------------------------------------------------
  // divider and reload configuration
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      div128_reg <= swdt_pkg::DIV128_RST;
      wdt_reload_value_reg <= swdt_pkg::RELOAD_RST;
    end
    else if (ovf)
    begin
      div128_reg <= swdt_pkg::DIV128_RST;
      wdt_reload_value_reg <= swdt_pkg::RELOAD_RST;
    end
    else if (cfg_write_in)
    begin
      div128_reg <= cfg_div128_in;
      wdt_reload_value_reg <= cfg_reload_in;
    end
  end

  assign ctl.run = is_running(state_reg);
  assign ctl.div128 = div128_reg;
  assign ctl.reload = wdt_reload_value_reg;
  // a service in the overflow cycle is too late
  assign ctl.service = service_watchdog_cmd_in && !ovf;

  // ----------------------------------------------------------------------------
  // reset generation and reset pin
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      hw_reset_out <= 1'b0;
    else
      hw_reset_out <= ovf;
  end

  // low from reset until end of init, and again after a watchdog reset
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      reset_out_n_out <= 1'b0;
    else if (ovf)
      reset_out_n_out <= 1'b0;
    else if (end_of_init_cmd_in)
      reset_out_n_out <= 1'b1;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      wdt_count_out <= swdt_pkg::CNT_RST;
    else
      wdt_count_out <= ctl.count;
  end

  assign wdt_active_out = is_running(state_reg);
  assign init_done_out = !is_pre_init(state_reg);

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  property p_ovf_reset;
    ovf |=> hw_reset_out && !reset_out_n_out && state_reg == swdt_pkg::SWDT_INIT_RUN;
  endproperty
  a_ovf_reset: assert property (p_ovf_reset)
    else $error("overflow did not raise reset and pull reset pin low");

  property p_reset_pulse;
    hw_reset_out |-> !$past(hw_reset_out) ##1 !hw_reset_out;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("internal reset is not a single-cycle pulse");

  property p_disable_locked;
    !is_pre_init(state_reg) && !ovf |=> !is_pre_init(state_reg) &&
      (is_running(state_reg) == $past(is_running(state_reg)));
  endproperty
  a_disable_locked: assert property (p_disable_locked)
    else $error("watchdog state changed after end of init");

  property p_disable_early;
    state_reg == swdt_pkg::SWDT_INIT_RUN && disable_watchdog_cmd_in && !end_of_init_cmd_in
      && !ovf |=> !wdt_active_out ##1 (!wdt_active_out || $past(ovf));
  endproperty
  a_disable_early: assert property (p_disable_early)
    else $error("disable before end of init was not accepted");

  property p_eoi_release;
    end_of_init_cmd_in && !ovf |=> reset_out_n_out && init_done_out;
  endproperty
  a_eoi_release: assert property (p_eoi_release)
    else $error("end of init did not release the reset pin");

  property p_pin_low_pre_init;
    is_pre_init(state_reg) && !$past(end_of_init_cmd_in) |-> !reset_out_n_out;
  endproperty
  a_pin_low_pre_init: assert property (p_pin_low_pre_init)
    else $error("reset pin released before end of init");

  property p_defaults_after_ovf;
    $past(ovf) |-> !div128_reg && wdt_reload_value_reg == swdt_pkg::RELOAD_RST
      && ctl.count == swdt_pkg::CNT_RST;
  endproperty
  a_defaults_after_ovf: assert property (p_defaults_after_ovf)
    else $error("watchdog reset did not restore default configuration");

  property p_count_mirror;
    ##1 wdt_count_out == $past(ctl.count);
  endproperty
  a_count_mirror: assert property (p_count_mirror)
    else $error("count output does not follow the counter");

endmodule

// ### testbench/swdt_top_test.sv
// self-checking bench of the startup watchdog supervisor
`timescale 1ns/10ps
module swdt_top_test;
  logic sys_clk = 1'h0;
  logic arst_n = 1'h0;
  logic srv = 1'h0;
  logic dis = 1'h0;
  logic eoi = 1'h0;
  logic cfg_wr = 1'h0;
  logic cfg_div = 1'h0;
  logic [swdt_pkg::REL_W-1:0] cfg_rel = 8'h00;
  logic hw_rst;
  logic rst_pin_n;
  logic active;
  logic done;
  logic [swdt_pkg::CNT_W-1:0] count;
  logic [swdt_pkg::CNT_W-1:0] snap;
  int miscompares = 0;
  int checked = 0;
  int n;

  always #50 sys_clk = ~sys_clk;

  swdt_top dut (
    .sys_clk_in(sys_clk),
    .arst_n_in(arst_n),
    .service_watchdog_cmd_in(srv),
    .disable_watchdog_cmd_in(dis),
    .end_of_init_cmd_in(eoi),
    .cfg_write_in(cfg_wr),
    .cfg_div128_in(cfg_div),
    .cfg_reload_in(cfg_rel),
    .hw_reset_out(hw_rst),
    .reset_out_n_out(rst_pin_n),
    .wdt_active_out(active),
    .init_done_out(done),
    .wdt_count_out(count)
  );

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #10;
  endtask

  task automatic cmd(input logic s, input logic d, input logic e);
    {srv, dis, eoi} = {s, d, e};
    cyc(1);
    {srv, dis, eoi} = 3'h0;
  endtask

  task automatic set_cfg(input logic div, input logic [7:0] rel);
    cfg_div = div;
    cfg_rel = rel;
    cfg_wr = 1'h1;
    cyc(1);
    cfg_wr = 1'h0;
  endtask

  task automatic do_reset();
    arst_n = 1'h0;
    cyc(3);
    chk("hw_reset", 16'(hw_rst), 16'h0000);
    chk("pin", 16'(rst_pin_n), 16'h0000);
    chk("active", 16'(active), 16'h0001);
    chk("done", 16'(done), 16'h0000);
    chk("count", count, 16'h0000);
    arst_n = 1'h1;
    cyc(1);
    chk("count first edge", count, 16'h0000);
  endtask

  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_rate();
    do_reset();
    cyc(10);
    snap = count;
    cyc(256);
    chk("rate div2", count - snap, 16'h0080);
    set_cfg(1'h1, 8'h00);
    cyc(300);
    snap = count;
    cyc(1280);
    chk("rate div128", count - snap, 16'h000A);
  endtask

  task automatic t_reload();
    do_reset();
    set_cfg(1'h0, 8'hAB);
    cmd(1'h1, 1'h0, 1'h0);
    cyc(1);
    chk("reload", count, 16'hAB00);
  endtask

  // periodic service with reload FF keeps the count from wrapping
  task automatic t_service();
    do_reset();
    set_cfg(1'h0, 8'hFF);
    repeat (3)
    begin
      cmd(1'h1, 1'h0, 1'h0);
      cyc(500);
      chk("serviced count", count, 16'hFFF9);
    end
  endtask

  task automatic t_overflow();
    do_reset();
    cmd(1'h0, 1'h0, 1'h1);
    chk("pin after init", 16'(rst_pin_n), 16'h0001);
    set_cfg(1'h0, 8'hFF);
    cmd(1'h1, 1'h0, 1'h0);
    n = 0;
    while (hw_rst !== 1'h1 && n < 600)
    begin
      cyc(1);
      n++;
    end
    chk("overflow time", 16'(n), 16'h0200);
    chk("pin on overflow", 16'(rst_pin_n), 16'h0000);
    chk("active after overflow", 16'(active), 16'h0001);
    chk("done after overflow", 16'(done), 16'h0000);
    cyc(1);
    chk("hw_reset pulse", 16'(hw_rst), 16'h0000);
    cmd(1'h1, 1'h0, 1'h0);
    cyc(1);
    chk("reload cleared", count, 16'h0000);
  endtask

  task automatic t_disable();
    do_reset();
    cmd(1'h0, 1'h1, 1'h0);
    chk("disabled", 16'(active), 16'h0000);
    cyc(2);
    snap = count;
    cyc(20);
    chk("frozen", count, snap);
    set_cfg(1'h0, 8'h12);
    cmd(1'h1, 1'h0, 1'h0);
    cyc(1);
    chk("service while off", count, 16'h1200);
    chk("still off", 16'(active), 16'h0000);
    cmd(1'h0, 1'h0, 1'h1);
    chk("done", 16'(done), 16'h0001);
    chk("pin released", 16'(rst_pin_n), 16'h0001);
  endtask

  task automatic t_late_disable();
    do_reset();
    cmd(1'h0, 1'h0, 1'h1);
    cyc(1);
    cmd(1'h0, 1'h1, 1'h0);
    chk("late disable", 16'(active), 16'h0001);
    cyc(2);
    snap = count;
    cyc(20);
    chk("still counting", count - snap, 16'h000A);
    do_reset();
    cmd(1'h0, 1'h1, 1'h1);
    chk("same cycle active", 16'(active), 16'h0001);
    chk("same cycle done", 16'(done), 16'h0001);
  endtask

  // ----------------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------------
  initial
  begin
    t_rate();
    t_reload();
    t_service();
    t_overflow();
    t_disable();
    t_late_disable();
    end_of_test();
  end

  initial
  begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    $display("[ERR] watchdog expired");
    end_of_test();
  end
endmodule
